// >>> rtc_pkg.sv
// Shared constants and types for the tag configuration-word feature link
package rtc_pkg;
   localparam int CLK_HZ = 20_000_000;
   localparam int CYC_PER_US = CLK_HZ / 1_000_000;
   // Typical write times in microseconds for erased target memory
   localparam int WR_WORD_US = 1000;
   localparam int WR_BLOCK_US = 1800;
   localparam int WR_WORD_CYC = WR_WORD_US * CYC_PER_US;
   localparam int WR_BLOCK_CYC = WR_BLOCK_US * CYC_PER_US;
   // Configuration word bit addresses in the EPC bank
   localparam logic [11:0] BIT_PAR_ENC = 12'h202;
   localparam logic [11:0] BIT_PWR_IND = 12'h204;
   localparam logic [11:0] BIT_BS_MAX = 12'h209;
   localparam logic [11:0] BIT_PSF = 12'h20F;
   localparam logic [7:0] LEN_ONE = 8'h01;
   // Word view: word 20h, bit 15 of the word is the MSB on air
   localparam logic [7:0] CFG_WORD = 8'h20;
   localparam int CFG_BS_POS = 6;
   localparam int CFG_PSF_POS = 0;
   localparam logic BS_MAX_RST = 1'b1;
   localparam logic PSF_RST = 1'b0;
   localparam logic [7:0] EPC_FIRST = 8'h02;
   localparam int EPC_WORDS = 6;
   localparam int EPC_BITS = 96;
   localparam int SERIAL_BITS = 48;
   localparam logic [15:0] FIXED_HANDLE = 16'hAAAA;
   localparam logic [15:0] LFSR_SEED = 16'hACE1;
   // Power in centi-dBm; check level is write sensitivity less 1 dB
   localparam int PWR_WRITE_SENS_CDBM = -1600;
   localparam int PWR_MARGIN_CDBM = 100;
   localparam int PWR_THRESH_CDBM = PWR_WRITE_SENS_CDBM - PWR_MARGIN_CDBM;
   localparam logic [1:0] SYNC_DONE = 2'h2;
   // Reader register map (byte offsets)
   localparam logic [7:0] REG_CMD = 8'h00;
   localparam logic [7:0] REG_ARG = 8'h04;
   localparam logic [7:0] REG_HANDLE = 8'h08;
   localparam logic [7:0] REG_WDATA = 8'h0C;
   localparam logic [7:0] REG_STATUS = 8'h10;
   localparam logic [7:0] REG_RSP0 = 8'h14;
   localparam logic [7:0] REG_RSP1 = 8'h18;
   localparam logic [7:0] REG_RSP2 = 8'h1C;
   localparam logic [7:0] REG_TXPWR = 8'h20;
   localparam int CMD_ARM_POS = 3;
   typedef enum logic [2:0] {CMD_SELECT, CMD_QUERY, CMD_ACK, CMD_READ, CMD_WRITE, CMD_BLOCK_WRITE} rtc_cmd_t;
   typedef enum logic [2:0] {RSP_RN16, RSP_EPC, RSP_DATA, RSP_DONE, RSP_ERROR} rtc_rsp_t;
endpackage : rtc_pkg

// >>> rtc_air_if.sv
// Command-level air link between reader and tag
interface rtc_air_if;
   logic cmd_valid;
   rtc_pkg::rtc_cmd_t cmd;
   logic [11:0] ptr;
   logic [7:0] len;
   logic mask;
   logic trunc;
   logic [15:0] handle;
   logic [31:0] wdata;
   logic rsp_valid;
   rtc_pkg::rtc_rsp_t rsp_kind;
   logic [rtc_pkg::EPC_BITS-1:0] rsp_data;
   logic rsp_strong;
   logic busy;
   modport reader (output cmd_valid, cmd, ptr, len, mask, trunc, handle, wdata,
                   input rsp_valid, rsp_kind, rsp_data, rsp_strong, busy);
   modport tag (input cmd_valid, cmd, ptr, len, mask, trunc, handle, wdata,
                output rsp_valid, rsp_kind, rsp_data, rsp_strong, busy);
endinterface : rtc_air_if

// >>> rtc_write_timer.sv
// Memory write duration timer
module rtc_write_timer #(
   parameter int WORD_CYC = rtc_pkg::WR_WORD_CYC,
   parameter int BLOCK_CYC = rtc_pkg::WR_BLOCK_CYC
) (
   input wire logic i_sys_clk,
   input wire logic i_srst,
   input wire logic i_start,
   input wire logic i_block,
   output logic o_busy,
   output logic o_done
);
   localparam int CW = $clog2(BLOCK_CYC + 1);
   logic [CW-1:0] cnt_q;
   if (WORD_CYC < 1 || BLOCK_CYC < WORD_CYC) begin : g_bad_counts
      $error("rtc_write_timer: bad cycle counts");
   end
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         cnt_q <= '0;
      end else if (i_start && !o_busy) begin
         cnt_q <= i_block ? CW'(BLOCK_CYC) : CW'(WORD_CYC);
      end else if (cnt_q != '0) begin
         cnt_q <= cnt_q - CW'(1);
      end
   end
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         o_busy <= 1'b0;
         o_done <= 1'b0;
      end else begin
         o_busy <= (i_start && !o_busy) || cnt_q > CW'(1);
         o_done <= o_busy && cnt_q == CW'(1);
      end
   end
endmodule : rtc_write_timer

// >>> rtc_tag.sv
// Tag end: configuration-word features driven over the air link
// Notes on behaviour
// - Two backscatter levels, maximum by default
// - Shipped EPC carries the factory serial number
// - Action bit 202h arms parallel encoding
// - Armed tags enter OPEN on QUERY, handle AAAAh
// - Every OPEN tag executes the same write
// - All tags reply together; reader tolerates collision
// - Select on 204h checks power for writing
// - Check level is write sensitivity minus 1dB
// - Power check pass means select matches
// - Tag joins inventory per its match result
// - Bit 20Fh is a free product status flag
// - Select on status flag limits replying tags
// - Word write 1 ms, block write 1.8 ms
// - Reader itself drives the parallel encoding sequence
// - Reader lowers power to isolate one tag
// - Action fires on exact pointer, length 1, mask 1
// - Truncated select on action bits is ignored
// - Triggered features last until chip reset
// - Writing 1 toggles a permanent bit; 0 ignored
//
// The strobed register port and the register addresses were left to the implementer.
module rtc_tag #(
   parameter int WR_WORD_CYC = rtc_pkg::WR_WORD_CYC,
   parameter int WR_BLOCK_CYC = rtc_pkg::WR_BLOCK_CYC,
   // Arbitrary value
   parameter logic [rtc_pkg::EPC_BITS-rtc_pkg::SERIAL_BITS-1:0] EPC_HEADER = 48'h3000_1234_0000
) (
   input wire logic i_sys_clk,
   input wire logic i_srst,
   rtc_air_if.tag air,
   input wire logic signed [15:0] i_rx_power_cdbm,
   input wire logic [rtc_pkg::SERIAL_BITS-1:0] i_factory_serial,
   output logic o_backscatter_max,
   output logic o_par_enc,
   output logic o_psf,
   output logic o_sel_match,
   output logic o_write_busy
);
   typedef enum logic [2:0] {ST_READY, ST_REPLY, ST_ACKED, ST_OPEN} rtc_state_t;
   rtc_state_t state_q;
   logic signed [15:0] pwr_s1_q, pwr_s2_q;
   logic [rtc_pkg::SERIAL_BITS-1:0] ser_s1_q, ser_s2_q;
   logic [1:0] init_cnt_q;
   logic load_epc;
   logic [15:0] epc_q [rtc_pkg::EPC_WORDS];
   logic [rtc_pkg::EPC_BITS-1:0] epc_flat, epc_init;
   logic bs_max_q, par_enc_q, psf_q, match_q;
   logic [15:0] handle_q, lfsr_q;
   logic [7:0] wr_addr_q;
   logic [31:0] wr_data_q;
   logic wr_block_q, wr_done;
   logic rsp_valid_q;
   rtc_pkg::rtc_rsp_t rsp_kind_q;
   logic [rtc_pkg::EPC_BITS-1:0] rsp_data_q;
   logic sel, qry, ack, rd, wr, addressed, pwr_ok, act_ok, wr_start, wr_ok;
   logic [15:0] w0_data, cfg_wr, rd_word;
   logic [7:0] wr_addr1, cmd_addr1;

   function automatic logic addr_ok(input logic [7:0] a);
      addr_ok = (a >= rtc_pkg::EPC_FIRST && a < rtc_pkg::EPC_FIRST + 8'(rtc_pkg::EPC_WORDS))
                || a == rtc_pkg::CFG_WORD;
   endfunction : addr_ok

   // Analog power level and straps come from outside the clock domain
   always_ff @(posedge i_sys_clk) begin
      pwr_s1_q <= i_rx_power_cdbm;
      pwr_s2_q <= pwr_s1_q;
      ser_s1_q <= i_factory_serial;
      ser_s2_q <= ser_s1_q;
   end
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         init_cnt_q <= '0;
      end else if (init_cnt_q != rtc_pkg::SYNC_DONE) begin
         init_cnt_q <= init_cnt_q + 2'h1;
      end
   end
   assign load_epc = init_cnt_q == rtc_pkg::SYNC_DONE - 2'h1;

   assign sel = air.cmd_valid && air.cmd == rtc_pkg::CMD_SELECT;
   assign qry = air.cmd_valid && air.cmd == rtc_pkg::CMD_QUERY;
   assign ack = air.cmd_valid && air.cmd == rtc_pkg::CMD_ACK;
   assign rd = air.cmd_valid && air.cmd == rtc_pkg::CMD_READ;
   assign wr = air.cmd_valid && (air.cmd == rtc_pkg::CMD_WRITE || air.cmd == rtc_pkg::CMD_BLOCK_WRITE);
   assign act_ok = !air.trunc && air.len == rtc_pkg::LEN_ONE && air.mask;
   assign pwr_ok = pwr_s2_q >= 16'(rtc_pkg::PWR_THRESH_CDBM);
   // The shared handle is held in handle_q once OPEN
   assign addressed = (state_q == ST_ACKED || state_q == ST_OPEN) && air.handle == handle_q;
   assign cmd_addr1 = air.ptr[7:0] + 8'h01;
   assign wr_ok = addr_ok(air.ptr[7:0]) && (air.cmd == rtc_pkg::CMD_WRITE || addr_ok(cmd_addr1));
   assign wr_start = wr && addressed && !o_write_busy && wr_ok;

   rtc_write_timer #(.WORD_CYC(WR_WORD_CYC), .BLOCK_CYC(WR_BLOCK_CYC)) u_timer (
      .i_sys_clk(i_sys_clk),
      .i_srst(i_srst),
      .i_start(wr_start),
      .i_block(air.cmd == rtc_pkg::CMD_BLOCK_WRITE),
      .o_busy(o_write_busy),
      .o_done(wr_done)
   );

   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         wr_addr_q <= '0;
         wr_data_q <= '0;
         wr_block_q <= 1'b0;
      end else if (wr_start) begin
         wr_addr_q <= air.ptr[7:0];
         wr_data_q <= air.wdata;
         wr_block_q <= air.cmd == rtc_pkg::CMD_BLOCK_WRITE;
      end
   end
   // Block write: first word from the upper half, second from the lower
   assign wr_addr1 = wr_addr_q + 8'h01;
   assign epc_init = {EPC_HEADER, ser_s2_q};
   assign w0_data = wr_block_q ? wr_data_q[31:16] : wr_data_q[15:0];

   genvar gi;
   generate
      for (gi = 0; gi < rtc_pkg::EPC_WORDS; gi++) begin : g_epc
         localparam logic [7:0] WADDR = rtc_pkg::EPC_FIRST + 8'(gi);
         always_ff @(posedge i_sys_clk) begin
            if (i_srst) begin
               epc_q[gi] <= '0;
            end else if (load_epc) begin
               epc_q[gi] <= epc_init[rtc_pkg::EPC_BITS-1-16*gi -: 16];
            end else if (wr_done && wr_addr_q == WADDR) begin
               epc_q[gi] <= w0_data;
            end else if (wr_done && wr_block_q && wr_addr1 == WADDR) begin
               epc_q[gi] <= wr_data_q[15:0];
            end
         end
         assign epc_flat[rtc_pkg::EPC_BITS-1-16*gi -: 16] = epc_q[gi];
      end
   endgenerate

   always_comb begin
      cfg_wr = '0;
      if (wr_done && wr_addr_q == rtc_pkg::CFG_WORD) begin
         cfg_wr = w0_data;
      end else if (wr_done && wr_block_q && wr_addr1 == rtc_pkg::CFG_WORD) begin
         cfg_wr = wr_data_q[15:0];
      end
   end
   // Permanent bits toggle; state is not kept across power-up here
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         bs_max_q <= rtc_pkg::BS_MAX_RST;
         psf_q <= rtc_pkg::PSF_RST;
      end else begin
         bs_max_q <= bs_max_q ^ cfg_wr[rtc_pkg::CFG_BS_POS];
         psf_q <= psf_q ^ cfg_wr[rtc_pkg::CFG_PSF_POS];
      end
   end
   // Only a chip reset clears the armed feature
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         par_enc_q <= 1'b0;
      end else if (sel && act_ok && air.ptr == rtc_pkg::BIT_PAR_ENC) begin
         par_enc_q <= 1'b1;
      end
   end
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         match_q <= 1'b1;
      end else if (sel) begin
         if (air.ptr == rtc_pkg::BIT_PWR_IND) begin
            if (act_ok) begin
               match_q <= pwr_ok;
            end
         end else if (air.ptr == rtc_pkg::BIT_PAR_ENC) begin
            match_q <= match_q;
         end else if (air.ptr == rtc_pkg::BIT_PSF && air.len == rtc_pkg::LEN_ONE) begin
            match_q <= psf_q == air.mask;
         end else if (air.ptr == rtc_pkg::BIT_BS_MAX && air.len == rtc_pkg::LEN_ONE) begin
            match_q <= bs_max_q == air.mask;
         end else begin
            match_q <= 1'b1;
         end
      end
   end
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         lfsr_q <= rtc_pkg::LFSR_SEED;
      end else begin
         lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
      end
   end
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         state_q <= ST_READY;
         handle_q <= '0;
      end else if (qry) begin
         if (par_enc_q) begin
            state_q <= ST_OPEN;
            handle_q <= rtc_pkg::FIXED_HANDLE;
         end else if (match_q) begin
            state_q <= ST_REPLY;
            handle_q <= lfsr_q;
         end else begin
            state_q <= ST_READY;
         end
      end else if (ack && state_q == ST_REPLY && air.handle == handle_q) begin
         state_q <= ST_ACKED;
      end
   end

   always_comb begin
      rd_word = '0;
      if (air.ptr[7:0] == rtc_pkg::CFG_WORD) begin
         rd_word[rtc_pkg::CFG_BS_POS] = bs_max_q;
         rd_word[rtc_pkg::CFG_PSF_POS] = psf_q;
      end else if (addr_ok(air.ptr[7:0])) begin
         rd_word = epc_q[3'(air.ptr[7:0] - rtc_pkg::EPC_FIRST)];
      end
   end
   // Armed tags all answer at once; collision is left to the reader
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         rsp_valid_q <= 1'b0;
         rsp_kind_q <= rtc_pkg::RSP_RN16;
         rsp_data_q <= '0;
      end else begin
         rsp_valid_q <= 1'b0;
         if (qry && (par_enc_q || match_q)) begin
            rsp_valid_q <= 1'b1;
            rsp_kind_q <= rtc_pkg::RSP_RN16;
            rsp_data_q <= {80'h0, par_enc_q ? rtc_pkg::FIXED_HANDLE : lfsr_q};
         end else if (ack && (state_q == ST_REPLY || state_q == ST_OPEN) && air.handle == handle_q) begin
            rsp_valid_q <= 1'b1;
            rsp_kind_q <= rtc_pkg::RSP_EPC;
            rsp_data_q <= epc_flat;
         end else if (rd && addressed) begin
            rsp_valid_q <= 1'b1;
            rsp_kind_q <= addr_ok(air.ptr[7:0]) ? rtc_pkg::RSP_DATA : rtc_pkg::RSP_ERROR;
            rsp_data_q <= {80'h0, rd_word};
         end else if (wr && addressed && !wr_start) begin
            rsp_valid_q <= 1'b1;
            rsp_kind_q <= rtc_pkg::RSP_ERROR;
            rsp_data_q <= '0;
         end else if (wr_done) begin
            rsp_valid_q <= 1'b1;
            rsp_kind_q <= rtc_pkg::RSP_DONE;
            rsp_data_q <= '0;
         end
      end
   end

   assign air.rsp_valid = rsp_valid_q;
   assign air.rsp_kind = rsp_kind_q;
   assign air.rsp_data = rsp_data_q;
   assign air.rsp_strong = bs_max_q;
   assign air.busy = o_write_busy;
   assign o_backscatter_max = bs_max_q;
   assign o_par_enc = par_enc_q;
   assign o_psf = psf_q;
   assign o_sel_match = match_q;
endmodule : rtc_tag

// >>> rtc_reader.sv
// Reader end: register-driven command issue over the air link
module rtc_reader (
   input wire logic i_sys_clk,
   input wire logic i_srst,
   rtc_air_if.reader air,
   input wire logic [7:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [31:0] o_rdata,
   output logic signed [15:0] o_tx_power_cdbm
);
   logic cmd_valid_q, mask_q, trunc_q, par_mode_q, rsp_new_q;
   rtc_pkg::rtc_cmd_t cmd_q;
   logic [11:0] ptr_q;
   logic [7:0] len_q;
   logic [15:0] handle_q;
   logic [31:0] wdata_q;
   logic [11:0] arg_ptr_q;
   logic [7:0] arg_len_q;
   logic arg_mask_q, arg_trunc_q;
   rtc_pkg::rtc_rsp_t rsp_kind_q;
   logic [rtc_pkg::EPC_BITS-1:0] rsp_data_q;
   logic cmd_wr, arm;

   assign cmd_wr = i_wr && i_addr == rtc_pkg::REG_CMD;
   assign arm = i_wdata[rtc_pkg::CMD_ARM_POS];
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         arg_ptr_q <= '0;
         arg_len_q <= '0;
         arg_mask_q <= 1'b0;
         arg_trunc_q <= 1'b0;
         handle_q <= '0;
         wdata_q <= '0;
         o_tx_power_cdbm <= '0;
      end else if (i_wr) begin
         if (i_addr == rtc_pkg::REG_ARG) begin
            arg_ptr_q <= i_wdata[11:0];
            arg_len_q <= i_wdata[23:16];
            arg_mask_q <= i_wdata[24];
            arg_trunc_q <= i_wdata[25];
         end
         if (i_addr == rtc_pkg::REG_HANDLE) handle_q <= i_wdata[15:0];
         if (i_addr == rtc_pkg::REG_WDATA) wdata_q <= i_wdata;
         // Lowering power isolates the one tag that can still write
         if (i_addr == rtc_pkg::REG_TXPWR) o_tx_power_cdbm <= i_wdata[15:0];
      end
   end
   // Arm issues the exact single-bit select; later commands use the shared handle
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         cmd_valid_q <= 1'b0;
         cmd_q <= rtc_pkg::CMD_SELECT;
         ptr_q <= '0;
         len_q <= '0;
         mask_q <= 1'b0;
         trunc_q <= 1'b0;
         par_mode_q <= 1'b0;
      end else begin
         cmd_valid_q <= cmd_wr;
         if (cmd_wr && arm) begin
            cmd_q <= rtc_pkg::CMD_SELECT;
            ptr_q <= rtc_pkg::BIT_PAR_ENC;
            len_q <= rtc_pkg::LEN_ONE;
            mask_q <= 1'b1;
            trunc_q <= 1'b0;
            par_mode_q <= 1'b1;
         end else if (cmd_wr) begin
            cmd_q <= rtc_pkg::rtc_cmd_t'(i_wdata[2:0]);
            ptr_q <= arg_ptr_q;
            len_q <= arg_len_q;
            mask_q <= arg_mask_q;
            trunc_q <= arg_trunc_q;
         end
      end
   end
   // A collided reply is taken as is, never decoded (set wins over clear)
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         rsp_new_q <= 1'b0;
         rsp_kind_q <= rtc_pkg::RSP_RN16;
         rsp_data_q <= '0;
      end else if (air.rsp_valid) begin
         rsp_new_q <= 1'b1;
         rsp_kind_q <= air.rsp_kind;
         rsp_data_q <= air.rsp_data;
      end else if (cmd_wr) begin
         rsp_new_q <= 1'b0;
      end
   end
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         o_rdata <= '0;
      end else if (i_rd) begin
         unique case (i_addr)
            rtc_pkg::REG_ARG: o_rdata <= {6'h00, arg_trunc_q, arg_mask_q, arg_len_q, 4'h0, arg_ptr_q};
            rtc_pkg::REG_HANDLE: o_rdata <= {16'h0000, handle_q};
            rtc_pkg::REG_WDATA: o_rdata <= wdata_q;
            rtc_pkg::REG_STATUS: o_rdata <= {24'h0, air.rsp_strong, par_mode_q, air.busy, rsp_new_q, 1'b0, rsp_kind_q};
            rtc_pkg::REG_RSP0: o_rdata <= rsp_data_q[31:0];
            rtc_pkg::REG_RSP1: o_rdata <= rsp_data_q[63:32];
            rtc_pkg::REG_RSP2: o_rdata <= rsp_data_q[95:64];
            rtc_pkg::REG_TXPWR: o_rdata <= {16'h0000, o_tx_power_cdbm};
            default: o_rdata <= '0;
         endcase
      end else begin
         o_rdata <= '0;
      end
   end
   assign air.cmd_valid = cmd_valid_q;
   assign air.cmd = cmd_q;
   assign air.ptr = ptr_q;
   assign air.len = len_q;
   assign air.mask = mask_q;
   assign air.trunc = trunc_q;
   assign air.handle = par_mode_q ? rtc_pkg::FIXED_HANDLE : handle_q;
   assign air.wdata = wdata_q;
endmodule : rtc_reader

// >>> rtc_air_properties.sv
// Concurrent checks on the air link between reader and tag
module rtc_air_properties #(
   parameter int WORD_CYC = 20,
   parameter int BLOCK_CYC = 30
) (
   input wire logic i_sys_clk,
   input wire logic i_srst,
   input wire logic cmd_valid,
   input wire rtc_pkg::rtc_cmd_t cmd,
   input wire logic [11:0] ptr,
   input wire logic [7:0] len,
   input wire logic mask,
   input wire logic trunc,
   input wire logic rsp_valid,
   input wire rtc_pkg::rtc_rsp_t rsp_kind,
   input wire logic [95:0] rsp_data,
   input wire logic rsp_strong,
   input wire logic busy
);
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_srst);
   logic armed_q;
   // Only reset may drop the armed state
   always_ff @(posedge i_sys_clk) begin
      if (i_srst)
         armed_q <= 1'b0;
      else if (cmd_valid && cmd == rtc_pkg::CMD_SELECT && ptr == rtc_pkg::BIT_PAR_ENC && len == rtc_pkg::LEN_ONE
               && mask && !trunc)
         armed_q <= 1'b1;
   end
   sequence s_done;
      rsp_valid && rsp_kind == rtc_pkg::RSP_DONE;
   endsequence
   sequence s_start(k);
      $rose(busy) && $past(cmd) == k;
   endsequence
   a_busy_cause: assert property ($rose(busy) |-> $past(cmd_valid))
      else $error("busy rose without a command");
   a_word_time: assert property (s_start(rtc_pkg::CMD_WRITE) |-> ##(WORD_CYC+1) s_done)
      else $error("word write done at wrong time");
   a_block_time: assert property (s_start(rtc_pkg::CMD_BLOCK_WRITE) |-> ##(BLOCK_CYC+1) s_done)
      else $error("block write done at wrong time");
   a_busy_holds: assert property ($rose(busy) |-> busy [*6])
      else $error("busy dropped early");
   a_done_follows: assert property ($fell(busy) && !$past(i_srst) |-> ##[0:1] s_done)
      else $error("no done after busy");
   a_reply_cause: assert property (rsp_valid |-> $past(cmd_valid) || $past(busy) || $past(busy, 2))
      else $error("reply without cause");
   a_par_query: assert property (armed_q && cmd_valid && cmd == rtc_pkg::CMD_QUERY |=>
      rsp_valid && rsp_kind == rtc_pkg::RSP_RN16 && rsp_data[15:0] == rtc_pkg::FIXED_HANDLE)
      else $error("armed query without shared handle");
   a_strong_reset: assert property ($fell(i_srst) |-> rsp_strong && !busy)
      else $error("backscatter not maximum after reset");
   a_strong_by_write: assert property ($changed(rsp_strong) && !$past(i_srst) |-> s_done or
      ($past(rsp_valid) && $past(rsp_kind) == rtc_pkg::RSP_DONE))
      else $error("backscatter level changed without write");
endmodule : rtc_air_properties

// >>> test_rfid_tag_config_word_features.sv
// Self-checking bench: reader end and tag end joined over the air link
module test_rfid_tag_config_word_features;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [47:0] HDR = 48'h1234_5678_9ABC;
   localparam logic [11:0] CFG = {4'h0, rtc_pkg::CFG_WORD};
   logic i_sys_clk = 1'b0;
   logic i_srst = 1'b1;
   logic [7:0] i_addr = 8'h00;
   logic [31:0] i_wdata = 32'h0;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic chk = 1'b0;
   logic [31:0] o_rdata;
   logic signed [15:0] pwr;
   logic [47:0] serial;
   logic [31:0] h;
   int seed = 50154;
   int fail_count = 0;
   int n_tests = 0;
   logic [31:0] exp_q[$];
   logic [31:0] msk_q[$];
   string nm_q[$];
   rtc_air_if air ();
   rtc_reader u_rtc_reader (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .air(air.reader), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_tx_power_cdbm(pwr));
   rtc_tag #(.WR_WORD_CYC(20), .WR_BLOCK_CYC(30), .EPC_HEADER(HDR)) u_rtc_tag (.i_sys_clk(i_sys_clk),
      .i_srst(i_srst), .air(air.tag), .i_rx_power_cdbm(pwr), .i_factory_serial(serial), .o_backscatter_max(),
      .o_par_enc(), .o_psf(), .o_sel_match(), .o_write_busy());
   rtc_air_properties #(.WORD_CYC(20), .BLOCK_CYC(30)) u_rtc_air_properties (.i_sys_clk(i_sys_clk),
      .i_srst(i_srst), .cmd_valid(air.cmd_valid), .cmd(air.cmd), .ptr(air.ptr), .len(air.len), .mask(air.mask),
      .trunc(air.trunc), .rsp_valid(air.rsp_valid), .rsp_kind(air.rsp_kind), .rsp_data(air.rsp_data),
      .rsp_strong(air.rsp_strong), .busy(air.busy));
   initial begin
      forever #25 i_sys_clk = ~i_sys_clk;
   end
   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : finish_test
   task automatic cmp(string n, logic [31:0] e, logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask : cmp
   task automatic chk_rsp(logic e, logic g);
      n_tests++;
      if (g !== e) begin
         fail_count++;
         $display("mismatch reply expected %b seen %b", e, g);
      end
   endtask : chk_rsp
   function automatic logic [31:0] arg(logic [11:0] p, logic [7:0] l, logic m, logic t);
      return {6'h00, t, m, l, 4'h0, p};
   endfunction : arg
   task automatic reg_wr(logic [7:0] a, logic [31:0] d);
      @(posedge i_sys_clk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_sys_clk);
      i_wr <= 1'b0;
   endtask : reg_wr
   // Expected value is queued; the monitor compares it a cycle later
   task automatic reg_rd(logic [7:0] a, logic [31:0] e, logic [31:0] m, string n);
      exp_q.push_back(e);
      msk_q.push_back(m);
      nm_q.push_back(n);
      @(posedge i_sys_clk);
      i_addr <= a;
      i_rd <= 1'b1;
      chk <= 1'b1;
      @(posedge i_sys_clk);
      i_rd <= 1'b0;
      chk <= 1'b0;
   endtask : reg_rd
   task automatic peek(logic [7:0] a, output logic [31:0] v);
      @(posedge i_sys_clk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_sys_clk);
      i_rd <= 1'b0;
      @(posedge i_sys_clk);
      v = o_rdata;
   endtask : peek
   task automatic wait_rsp(logic e);
      logic g;
      g = 1'b0;
      for (int k = 0; k < 40 && !g; k++) begin
         @(posedge i_sys_clk);
         g = (air.rsp_valid === 1'b1);
      end
      chk_rsp(e, g);
      if (e && !g) finish_test();
   endtask : wait_rsp
   task automatic exch(rtc_pkg::rtc_cmd_t c, logic [31:0] a, logic e, rtc_pkg::rtc_rsp_t k);
      reg_wr(rtc_pkg::REG_ARG, a);
      reg_wr(rtc_pkg::REG_CMD, 32'(c));
      wait_rsp(e);
      if (e) reg_rd(rtc_pkg::REG_STATUS, 32'h10 | 32'(k), 32'h17, "reply kind");
   endtask : exch
   initial begin
      logic p, c;
      logic [31:0] m;
      p = 1'b0;
      c = 1'b0;
      forever begin
         @(posedge i_sys_clk);
         if (p && c) begin
            m = msk_q.pop_front();
            cmp(nm_q.pop_front(), exp_q.pop_front() & m, o_rdata & m);
         end
         p = i_rd;
         c = chk;
      end
   end
   initial begin
      serial = 48'({$random(seed), $random(seed)});
      repeat (3) @(posedge i_sys_clk);
      i_srst <= 1'b0;
      repeat (3) @(posedge i_sys_clk);
      reg_rd(rtc_pkg::REG_STATUS, 32'h80, 32'hE0, "status after reset");
      reg_rd(8'hFC, 32'h0, 32'hFFFF_FFFF, "unmapped");
      exch(rtc_pkg::CMD_QUERY, 32'h0, 1'b1, rtc_pkg::RSP_RN16);
      peek(rtc_pkg::REG_RSP0, h);
      reg_wr(rtc_pkg::REG_HANDLE, h);
      exch(rtc_pkg::CMD_ACK, 32'h0, 1'b1, rtc_pkg::RSP_EPC);
      reg_rd(rtc_pkg::REG_RSP0, serial[31:0], 32'hFFFF_FFFF, "epc low");
      reg_rd(rtc_pkg::REG_RSP1, {HDR[15:0], serial[47:32]}, 32'hFFFF_FFFF, "epc mid");
      reg_rd(rtc_pkg::REG_RSP2, HDR[47:16], 32'hFFFF_FFFF, "epc high");
      exch(rtc_pkg::CMD_READ, arg(CFG, 8'h01, 1'b0, 1'b0), 1'b1, rtc_pkg::RSP_DATA);
      reg_rd(rtc_pkg::REG_RSP0, 32'h40, 32'hFFFF, "config word");
      reg_wr(rtc_pkg::REG_WDATA, 32'h41);
      reg_wr(rtc_pkg::REG_ARG, arg(CFG, 8'h01, 1'b0, 1'b0));
      reg_wr(rtc_pkg::REG_CMD, 32'(rtc_pkg::CMD_WRITE));
      reg_wr(rtc_pkg::REG_CMD, 32'(rtc_pkg::CMD_WRITE));
      wait_rsp(1'b1);
      reg_rd(rtc_pkg::REG_STATUS, 32'h10 | 32'(rtc_pkg::RSP_ERROR), 32'h17, "busy refusal");
      wait_rsp(1'b1);
      reg_rd(rtc_pkg::REG_STATUS, 32'h13, 32'h97, "toggle done");
      reg_wr(rtc_pkg::REG_WDATA, 32'h0);
      exch(rtc_pkg::CMD_WRITE, arg(CFG, 8'h01, 1'b0, 1'b0), 1'b1, rtc_pkg::RSP_DONE);
      exch(rtc_pkg::CMD_READ, arg(CFG, 8'h01, 1'b0, 1'b0), 1'b1, rtc_pkg::RSP_DATA);
      reg_rd(rtc_pkg::REG_RSP0, 32'h01, 32'hFFFF, "zero write kept");
      exch(rtc_pkg::CMD_SELECT, arg(rtc_pkg::BIT_PSF, 8'h01, 1'b0, 1'b0), 1'b0, rtc_pkg::RSP_RN16);
      exch(rtc_pkg::CMD_QUERY, 32'h0, 1'b0, rtc_pkg::RSP_RN16);
      exch(rtc_pkg::CMD_SELECT, arg(rtc_pkg::BIT_PSF, 8'h01, 1'b1, 1'b0), 1'b0, rtc_pkg::RSP_RN16);
      exch(rtc_pkg::CMD_QUERY, 32'h0, 1'b1, rtc_pkg::RSP_RN16);
      // Power steps straddle the check level by one centi-dBm
      reg_wr(rtc_pkg::REG_TXPWR, 32'hFFFF_F95B);
      exch(rtc_pkg::CMD_SELECT, arg(rtc_pkg::BIT_PWR_IND, 8'h01, 1'b1, 1'b0), 1'b0, rtc_pkg::RSP_RN16);
      exch(rtc_pkg::CMD_QUERY, 32'h0, 1'b0, rtc_pkg::RSP_RN16);
      reg_wr(rtc_pkg::REG_TXPWR, 32'hFFFF_F95C);
      exch(rtc_pkg::CMD_SELECT, arg(rtc_pkg::BIT_PWR_IND, 8'h01, 1'b1, 1'b0), 1'b0, rtc_pkg::RSP_RN16);
      exch(rtc_pkg::CMD_QUERY, 32'h0, 1'b1, rtc_pkg::RSP_RN16);
      reg_wr(rtc_pkg::REG_TXPWR, 32'hFFFF_F8F8);
      exch(rtc_pkg::CMD_SELECT, arg(rtc_pkg::BIT_PWR_IND, 8'h01, 1'b1, 1'b1), 1'b0, rtc_pkg::RSP_RN16);
      exch(rtc_pkg::CMD_QUERY, 32'h0, 1'b1, rtc_pkg::RSP_RN16);
      exch(rtc_pkg::CMD_SELECT, arg(rtc_pkg::BIT_PWR_IND, 8'h02, 1'b1, 1'b0), 1'b0, rtc_pkg::RSP_RN16);
      exch(rtc_pkg::CMD_QUERY, 32'h0, 1'b1, rtc_pkg::RSP_RN16);
      reg_wr(rtc_pkg::REG_CMD, 32'h8 | 32'(rtc_pkg::CMD_SELECT));
      exch(rtc_pkg::CMD_QUERY, 32'h0, 1'b1, rtc_pkg::RSP_RN16);
      reg_rd(rtc_pkg::REG_RSP0, 32'(rtc_pkg::FIXED_HANDLE), 32'hFFFF, "shared handle");
      exch(rtc_pkg::CMD_ACK, 32'h0, 1'b1, rtc_pkg::RSP_EPC);
      reg_wr(rtc_pkg::REG_WDATA, 32'h1111_2222);
      exch(rtc_pkg::CMD_BLOCK_WRITE, arg({4'h0, rtc_pkg::EPC_FIRST}, 8'h01, 1'b0, 1'b0), 1'b1, rtc_pkg::RSP_DONE);
      exch(rtc_pkg::CMD_READ, arg({4'h0, rtc_pkg::EPC_FIRST}, 8'h01, 1'b0, 1'b0), 1'b1, rtc_pkg::RSP_DATA);
      reg_rd(rtc_pkg::REG_RSP0, 32'h1111, 32'hFFFF, "broadcast write");
      reg_rd(rtc_pkg::REG_STATUS, 32'h40, 32'h40, "parallel mode");
      i_srst <= 1'b1;
      repeat (3) @(posedge i_sys_clk);
      i_srst <= 1'b0;
      repeat (3) @(posedge i_sys_clk);
      reg_rd(rtc_pkg::REG_STATUS, 32'h80, 32'hE0, "status after second reset");
      repeat (3) @(posedge i_sys_clk);
      finish_test();
   end
endmodule : test_rfid_tag_config_word_features
